// >>> verilog/cmd_decoder_pkg.sv
package cmd_decoder_pkg;
  // Command word layout
  localparam int CMD_W    = 8;
  localparam int EXEC_BIT = 7;
  localparam int CODE_HI  = 6;
  localparam int CODE_LO  = 5;
  localparam int LINE_BIT = 4;
  localparam int INFO_HI  = 3;
  localparam int INFO_W   = 4;

  typedef enum logic [1:0] {
    CODE_CONT  = 2'b00,
    CODE_SCENE = 2'b01,
    CODE_CLEAR = 2'b10,
    CODE_GROUP = 2'b11
  } cmd_code_t;

  localparam logic [3:0] INFO_CLR_MEAS  = 4'h0;
  localparam logic [3:0] INFO_CLR_ERR   = 4'h1;
  localparam logic [3:0] INFO_CLR_JUDGE = 4'h2;

  // Per-line sequencing states
  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_MEAS = 2'b01
  } line_state_t;

  // APB register map
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_LINE0  = 8'h0C;
  localparam logic [7:0] OFF_LINE1  = 8'h10;

  // Control: a set bit makes judgement assert on a failed result, one bit per line
  localparam logic [1:0] CTRL_RST = 2'h3;

  // Status and mask bits
  localparam int ST_W     = 4;
  localparam int ST_ERR   = 0;
  localparam int ST_DONE0 = 1;
  localparam int ST_DONE1 = 2;
  localparam int ST_CMD   = 3;

  // Line register fields
  localparam int LF_SCENE = 0;
  localparam int LF_GROUP = 4;
  localparam int LF_CONT  = 8;
  localparam int LF_READY = 9;
  localparam int LF_ACK   = 10;
  localparam int LF_JUDGE = 11;
  localparam int LF_VALUE = 16;
endpackage

// >>> verilog/line_unit.sv
`timescale 1ns/1ns
module line_unit
  import cmd_decoder_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              trigger,
  input  wire logic              continuous,
  input  wire logic              scene_load,
  input  wire logic              group_load,
  input  wire logic [INFO_W-1:0] info,
  input  wire logic              clear_meas,
  input  wire logic              clear_judge,
  input  wire logic              pol_on_fail,
  input  wire logic              result_valid,
  input  wire logic              result_pass,
  input  wire logic [DATA_W-1:0] result_value,
  output logic                   meas_start,
  output logic                   ready,
  output logic                   gate,
  output logic                   judge,
  output logic      [DATA_W-1:0] data_out,
  output logic      [DATA_W-1:0] stored_value,
  output logic      [INFO_W-1:0] scene,
  output logic      [INFO_W-1:0] group
);

  if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
    $error("line_unit: DATA_W must be 1 to 16");
  end

  typedef struct packed {
    line_state_t       st;
    logic              trig_d;
    logic              pend;
    logic              start;
    logic              ready;
    logic              gate;
    logic              judge;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] value;
    logic [INFO_W-1:0] scene;
    logic [INFO_W-1:0] group;
  } line_reg_t;

  line_reg_t state_r;
  line_reg_t state_nxt;

  // Next state: trigger edge, scene loads, clears, measurement sequence
  always_comb begin
    state_nxt        = state_r;
    state_nxt.start  = 1'b0;
    state_nxt.gate   = 1'b0;
    state_nxt.trig_d = trigger;
    if (trigger && !state_r.trig_d) begin
      state_nxt.pend = 1'b1;
    end
    if (scene_load) begin
      state_nxt.scene = info;
    end
    if (group_load) begin
      state_nxt.group = info;
    end
    if (clear_meas) begin
      state_nxt.value = '0;
    end
    if (clear_judge) begin
      state_nxt.judge = 1'b0;
      state_nxt.data  = '0;
    end
    case (state_r.st)
      LN_IDLE: begin
        if (state_nxt.pend || continuous) begin
          state_nxt.st    = LN_MEAS;
          state_nxt.start = 1'b1;
          state_nxt.ready = 1'b0;
          state_nxt.pend  = 1'b0;
        end
      end
      LN_MEAS: begin
        if (result_valid) begin
          state_nxt.st    = LN_IDLE;
          state_nxt.value = result_value;
          state_nxt.data  = result_value;
          state_nxt.judge = result_pass ^ pol_on_fail;
          state_nxt.gate  = 1'b1;
          state_nxt.ready = 1'b1;
        end
      end
      default: begin
        state_nxt.st = LN_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= '0;
      state_r.st    <= LN_IDLE;
      state_r.ready <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign meas_start   = state_r.start;
  assign ready        = state_r.ready;
  assign gate         = state_r.gate;
  assign judge        = state_r.judge;
  assign data_out     = state_r.data;
  assign stored_value = state_r.value;
  assign scene        = state_r.scene;
  assign group        = state_r.group;

endmodule

// >>> verilog/dual_line_parallel_command_decoder.sv
`timescale 1ns/1ns
module dual_line_parallel_command_decoder
  import cmd_decoder_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [CMD_W-1:0]  command_input_bits,
  input  wire logic              trigger_0,
  input  wire logic              trigger_1,
  input  wire logic              receiver_ready_ack_0,
  input  wire logic              receiver_ready_ack_1,
  input  wire logic              result_valid_0,
  input  wire logic              result_valid_1,
  input  wire logic              result_pass_0,
  input  wire logic              result_pass_1,
  input  wire logic [DATA_W-1:0] result_value_0,
  input  wire logic [DATA_W-1:0] result_value_1,
  output logic                   meas_start_0,
  output logic                   meas_start_1,
  output logic                   ready_0,
  output logic                   ready_1,
  output logic                   gate_0,
  output logic                   gate_1,
  output logic                   judgement_0,
  output logic                   judgement_1,
  output logic      [DATA_W-1:0] data_out_0,
  output logic      [DATA_W-1:0] data_out_1,
  output logic                   error_out,
  output logic                   irq
);

  if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
    $error("decoder: DATA_W must be 1 to 16");
  end

  typedef struct packed {
    logic             exec_d;
    logic [CMD_W-1:0] cmd;
    logic [1:0]       cont;
    logic [1:0]       scene_ld;
    logic [1:0]       group_ld;
    logic [1:0]       clr_meas;
    logic [1:0]       clr_judge;
    logic             err;
    logic [1:0]       ctrl;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  mask;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } dec_reg_t;

  dec_reg_t state_r;
  dec_reg_t state_nxt;

  logic [INFO_W-1:0] scene_0;
  logic [INFO_W-1:0] scene_1;
  logic [INFO_W-1:0] group_0;
  logic [INFO_W-1:0] group_1;
  logic [DATA_W-1:0] value_0;
  logic [DATA_W-1:0] value_1;

  // Command fields of the live input and of the held command
  logic              exec_in;
  logic              exec_rise;
  cmd_code_t         code_in;
  logic              line_in;
  logic [INFO_W-1:0] info_in;
  cmd_code_t         code_held;

  assign exec_in   = command_input_bits[EXEC_BIT];
  assign exec_rise = exec_in && !state_r.exec_d;
  assign code_in   = cmd_code_t'(command_input_bits[CODE_HI:CODE_LO]);
  assign line_in   = command_input_bits[LINE_BIT];
  assign info_in   = command_input_bits[INFO_HI:0];
  assign code_held = cmd_code_t'(state_r.cmd[CODE_HI:CODE_LO]);

  // Read word for one line register
  function automatic logic [31:0] line_word(
    input logic [INFO_W-1:0] scn,
    input logic [INFO_W-1:0] grp,
    input logic              cnt,
    input logic              rdy,
    input logic              ack,
    input logic              jdg,
    input logic [DATA_W-1:0] val
  );
    logic [31:0] w;
    w                       = '0;
    w[LF_SCENE +: INFO_W]   = scn;
    w[LF_GROUP +: INFO_W]   = grp;
    w[LF_CONT]              = cnt;
    w[LF_READY]             = rdy;
    w[LF_ACK]               = ack;
    w[LF_JUDGE]             = jdg;
    w[LF_VALUE +: DATA_W]   = val;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state: command decode, error, APB slave, interrupt
  always_comb begin
    logic            setup;
    logic            access;
    logic [ST_W-1:0] w1c;
    logic [ST_W-1:0] hw_set;
    setup     = psel && !penable;
    access    = psel && penable && state_r.pready;
    w1c       = '0;
    hw_set    = '0;
    state_nxt = state_r;
    state_nxt.exec_d    = exec_in;
    state_nxt.scene_ld  = '0;
    state_nxt.group_ld  = '0;
    state_nxt.clr_meas  = '0;
    state_nxt.clr_judge = '0;

    // Capture and decode once per execute rising edge
    if (exec_rise) begin
      state_nxt.cmd    = command_input_bits;
      hw_set[ST_CMD]   = 1'b1;
      case (code_in)
        CODE_CONT: begin
          state_nxt.cmd[INFO_HI:0] = '0;
        end
        CODE_SCENE: begin
          state_nxt.scene_ld[line_in] = 1'b1;
        end
        CODE_GROUP: begin
          state_nxt.group_ld[line_in] = 1'b1;
        end
        CODE_CLEAR: begin
          case (info_in)
            INFO_CLR_MEAS: begin
              state_nxt.clr_meas[line_in] = 1'b1;
            end
            INFO_CLR_ERR: begin
              state_nxt.err = 1'b0;
              w1c[ST_ERR]   = 1'b1;
            end
            INFO_CLR_JUDGE: begin
              state_nxt.clr_judge[line_in] = 1'b1;
            end
            default: begin
              state_nxt.err  = 1'b1;
              hw_set[ST_ERR] = 1'b1;
            end
          endcase
        end
        default: begin
          state_nxt.err  = 1'b1;
          hw_set[ST_ERR] = 1'b1;
        end
      endcase
    end

    // Continuous run lasts while execute stays high
    state_nxt.cont = '0;
    if (exec_in && (exec_rise ? code_in : code_held) == CODE_CONT) begin
      state_nxt.cont[exec_rise ? line_in
                               : state_r.cmd[LINE_BIT]] = 1'b1;
    end

    hw_set[ST_DONE0] = gate_0;
    hw_set[ST_DONE1] = gate_1;

    // APB: answer prepared in setup, access phase has pready high
    state_nxt.pready  = 1'b0;
    state_nxt.pslverr = 1'b0;
    if (setup) begin
      state_nxt.pready = 1'b1;
      state_nxt.prdata = '0;
      case (paddr)
        OFF_CTRL: begin
          state_nxt.prdata[1:0] = state_r.ctrl;
        end
        OFF_STATUS: begin
          state_nxt.prdata[ST_W-1:0] = state_r.status;
        end
        OFF_MASK: begin
          state_nxt.prdata[ST_W-1:0] = state_r.mask;
        end
        OFF_LINE0: begin
          state_nxt.pslverr = pwrite;
          state_nxt.prdata  = line_word(scene_0, group_0,
                                        state_r.cont[0], ready_0,
                                        receiver_ready_ack_0,
                                        judgement_0, value_0);
        end
        OFF_LINE1: begin
          state_nxt.pslverr = pwrite;
          state_nxt.prdata  = line_word(scene_1, group_1,
                                        state_r.cont[1], ready_1,
                                        receiver_ready_ack_1,
                                        judgement_1, value_1);
        end
        default: begin
          state_nxt.pslverr = 1'b1;
        end
      endcase
      if (pwrite) begin
        state_nxt.prdata = '0;
      end
    end else if (access) begin
      state_nxt.pslverr = state_r.pslverr;
      state_nxt.prdata  = state_r.prdata;
      if (pwrite && !state_r.pslverr) begin
        case (paddr)
          OFF_CTRL: begin
            state_nxt.ctrl = pwdata[1:0];
          end
          OFF_STATUS: begin
            w1c = w1c | pwdata[ST_W-1:0];
          end
          OFF_MASK: begin
            state_nxt.mask = pwdata[ST_W-1:0];
          end
          default: begin
            state_nxt.ctrl = state_r.ctrl;
          end
        endcase
      end
    end

    // Sticky status: a new event wins over a clear
    state_nxt.status = (state_r.status & ~w1c) | hw_set;
    state_nxt.irq    = |(state_nxt.status & state_nxt.mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= '0;
      state_r.ctrl <= CTRL_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata    = state_r.prdata;
  assign pready    = state_r.pready;
  assign pslverr   = state_r.pslverr;
  assign error_out = state_r.err;
  assign irq       = state_r.irq;

  ////////////////////////////////////////////////////////////////////////
  // One sequencer per line
  line_unit #(.DATA_W(DATA_W)) u_line0 (
    .pclk         (pclk),
    .presetn      (presetn),
    .trigger      (trigger_0),
    .continuous   (state_r.cont[0]),
    .scene_load   (state_r.scene_ld[0]),
    .group_load   (state_r.group_ld[0]),
    .info         (state_r.cmd[INFO_HI:0]),
    .clear_meas   (state_r.clr_meas[0]),
    .clear_judge  (state_r.clr_judge[0]),
    .pol_on_fail  (state_r.ctrl[0]),
    .result_valid (result_valid_0),
    .result_pass  (result_pass_0),
    .result_value (result_value_0),
    .meas_start   (meas_start_0),
    .ready        (ready_0),
    .gate         (gate_0),
    .judge        (judgement_0),
    .data_out     (data_out_0),
    .stored_value (value_0),
    .scene        (scene_0),
    .group        (group_0)
  );

  line_unit #(.DATA_W(DATA_W)) u_line1 (
    .pclk         (pclk),
    .presetn      (presetn),
    .trigger      (trigger_1),
    .continuous   (state_r.cont[1]),
    .scene_load   (state_r.scene_ld[1]),
    .group_load   (state_r.group_ld[1]),
    .info         (state_r.cmd[INFO_HI:0]),
    .clear_meas   (state_r.clr_meas[1]),
    .clear_judge  (state_r.clr_judge[1]),
    .pol_on_fail  (state_r.ctrl[1]),
    .result_valid (result_valid_1),
    .result_pass  (result_pass_1),
    .result_value (result_value_1),
    .meas_start   (meas_start_1),
    .ready        (ready_1),
    .gate         (gate_1),
    .judge        (judgement_1),
    .data_out     (data_out_1),
    .stored_value (value_1),
    .scene        (scene_1),
    .group        (group_1)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  exec_capture_a: assert property (exec_rise |=> state_r.cmd[CMD_W-1:CODE_LO]
      == $past(command_input_bits[CMD_W-1:CODE_LO]))
    else $error("command not captured on execute rise");

  scene_load_a: assert property (exec_rise && code_in == CODE_SCENE
      && !line_in |-> ##2 scene_0 == $past(info_in, 2))
    else $error("line 0 scene not loaded");

  other_line_a: assert property (exec_rise && code_in == CODE_SCENE
      && !line_in |-> ##2 scene_1 == $past(scene_1, 2))
    else $error("scene switch leaked to line 1");

  group_load_a: assert property (exec_rise && code_in == CODE_GROUP
      && line_in |-> ##2 group_1 == $past(info_in, 2))
    else $error("line 1 scene group not loaded");

  bad_cmd_err_a: assert property (exec_rise && code_in == CODE_CLEAR
      && info_in > INFO_CLR_JUDGE |=> error_out)
    else $error("undefined command did not raise error");

  clear_err_a: assert property (exec_rise && code_in == CODE_CLEAR
      && info_in == INFO_CLR_ERR |=> !error_out)
    else $error("error not cleared");

  clear_judge_a: assert property (exec_rise && code_in == CODE_CLEAR
      && info_in == INFO_CLR_JUDGE && !line_in ##1 !result_valid_0
      |=> !judgement_0 && data_out_0 == '0)
    else $error("line 0 judgement not cleared");

  judge_pol_a: assert property (gate_0 |-> judgement_0
      == ($past(result_pass_0) ^ $past(state_r.ctrl[0])))
    else $error("judgement polarity wrong");

  trig_start_a: assert property ($rose(trigger_0) && ready_0
      |=> meas_start_0)
    else $error("trigger did not start a measurement");

  cont_run_a: assert property (state_r.cont[1] && ready_1
      |=> meas_start_1)
    else $error("continuous run did not start a measurement");

  scene_cov: cover property (exec_rise && code_in == CODE_SCENE);
  err_clr_cov: cover property (error_out ##[1:50] !error_out);
  meas_cov: cover property (meas_start_0 ##[1:50] gate_0);
  irq_cov: cover property ($rose(irq));

endmodule

// >>> testbench/plc_model.sv
`timescale 1ns/1ns
module plc_model #(
  parameter int SETUP_CYC = 100000
) (
  input  wire logic       pclk,
  output logic      [7:0] command_input_bits,
  output logic            trigger_0,
  output logic            trigger_1,
  output logic            receiver_ready_ack_0,
  output logic            receiver_ready_ack_1
);
  // Lines idle low until the first command
  initial begin
    command_input_bits = 8'h00;
    trigger_0 = 1'b0;
    trigger_1 = 1'b0;
    receiver_ready_ack_0 = 1'b0;
    receiver_ready_ack_1 = 1'b0;
  end

  // Receiver-ready levels for both lines
  task automatic set_ack(input logic [1:0] a);
    receiver_ready_ack_0 <= a[0];
    receiver_ready_ack_1 <= a[1];
  endtask

  // Code, line and info settle before execute rises
  task automatic issue(input logic [7:0] cmd, input int hold);
    command_input_bits <= {1'b0, cmd[6:0]};
    repeat (SETUP_CYC) @(posedge pclk);
    command_input_bits <= {1'b1, cmd[6:0]};
    repeat (hold) @(posedge pclk);
    command_input_bits <= {1'b0, cmd[6:0]};
    repeat (2) @(posedge pclk);
  endtask

  // One trigger turn-on on the chosen line
  task automatic pulse(input logic line);
    if (line) trigger_1 <= 1'b1;
    else trigger_0 <= 1'b1;
    repeat (2) @(posedge pclk);
    trigger_0 <= 1'b0;
    trigger_1 <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// >>> testbench/dual_line_parallel_command_decoder_test.sv
`timescale 1ns/1ns
module dual_line_parallel_command_decoder_test
  import cmd_decoder_pkg::*;
();
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [7:0]        cmd_bits, d;
  logic              trig [2], rv [2], rp [2], ms [2], rdy [2], gate [2];
  logic              jdg [2], jx [2], ack [2];
  logic [7:0]        rval [2], dout [2];
  logic [3:0]        eng [2], scn [2], grp [2], v;
  logic [1:0]        c, ctrl;
  logic              error_out, irq, e, l;
  int                nst [2];
  int                n_fail, n_compared, seed, b, b0;

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  dual_line_parallel_command_decoder #(.DATA_W(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .command_input_bits(cmd_bits),
    .trigger_0(trig[0]), .trigger_1(trig[1]),
    .receiver_ready_ack_0(ack[0]), .receiver_ready_ack_1(ack[1]),
    .result_valid_0(rv[0]), .result_valid_1(rv[1]),
    .result_pass_0(rp[0]), .result_pass_1(rp[1]),
    .result_value_0(rval[0]), .result_value_1(rval[1]),
    .meas_start_0(ms[0]), .meas_start_1(ms[1]),
    .ready_0(rdy[0]), .ready_1(rdy[1]), .gate_0(gate[0]),
    .gate_1(gate[1]), .judgement_0(jdg[0]), .judgement_1(jdg[1]),
    .data_out_0(dout[0]), .data_out_1(dout[1]),
    .error_out(error_out), .irq(irq)
  );

  // Setup time shortened from 1 ms to keep the run short
  plc_model #(.SETUP_CYC(4)) u_plc (
    .pclk(pclk), .command_input_bits(cmd_bits),
    .trigger_0(trig[0]), .trigger_1(trig[1]),
    .receiver_ready_ack_0(ack[0]), .receiver_ready_ack_1(ack[1])
  );

  // Measurement engine answers each start after four cycles
  always @(posedge pclk) begin
    for (int i = 0; i < 2; i++) begin
      rv[i] <= (ms[i] !== 1'b1) && (eng[i] == 4'h1);
      if (ms[i] === 1'b1) begin
        eng[i] <= 4'h4;
        nst[i] <= nst[i] + 1;
      end else if (eng[i] == 4'h1) begin
        eng[i] <= 4'h0;
        rp[i] <= 1'($random(seed));
        rval[i] <= 8'($random(seed));
      end else if (eng[i] != 4'h0) begin
        eng[i] <= eng[i] - 4'h1;
      end
    end
  end

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tmo();
    n_fail++;
    summarize();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k == 16) tmo();
  endtask

  task automatic wait_gate(input logic ln);
    int k;
    for (k = 0; k < 64; k++) begin
      @(posedge pclk);
      if (gate[ln] === 1'b1) break;
    end
    if (k == 64) tmo();
  endtask

  // Main sequence
  initial begin
    seed = 32'h5D21;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    n_compared = 0;
    ctrl = CTRL_RST;
    for (int i = 0; i < 2; i++) begin
      {rv[i], rp[i], rval[i], eng[i], scn[i], grp[i], nst[i]} = '0;
    end
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({rdy[0], rdy[1], error_out, jdg[0], jdg[1]}, 5'h18);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(q[1:0], 2'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    apb(1'b1, OFF_LINE0, 32'hFFFF);
    chk(e, 1'b1);
    for (int i = 0; i < 8; i++) begin
      l = (i < 4) ? i[1] : 1'($random(seed));
      v = 4'($random(seed));
      c = i[0] ? CODE_GROUP : CODE_SCENE;
      u_plc.issue({1'b1, c, l, v}, 3);
      if (c == CODE_SCENE) scn[l] = v;
      else grp[l] = v;
      u_plc.set_ack(2'(i));
      for (int j = 0; j < 2; j++) begin
        apb(1'b0, OFF_LINE0 + 8'(4 * j), 32'h0);
        chk({q[LF_ACK], q[7:0]}, {i[j], grp[j], scn[j]});
      end
    end
    for (int i = 0; i < 6; i++) begin
      l = (i < 2) ? 1'(i) : 1'($random(seed));
      if (i == 3) begin
        apb(1'b1, OFF_CTRL, 32'h0);
        ctrl = 2'h0;
      end
      b = nst[l];
      u_plc.pulse(l);
      wait_gate(l);
      jx[l] = rp[l] ^ ctrl[l];
      chk(jdg[l], jx[l]);
      chk(dout[l], rval[l]);
      repeat (8) @(posedge pclk);
      chk(nst[l] - b, 1);
    end
    // Clears aimed at line 0, line 1 must stay
    l = 1'b0;
    d = rval[l];
    apb(1'b0, OFF_LINE0, 32'h0);
    chk(q[23:16], rval[l]);
    u_plc.issue({3'b110, l, INFO_CLR_MEAS}, 3);
    apb(1'b0, OFF_LINE0, 32'h0);
    chk({q[23:16], jdg[l], dout[l]}, {8'h00, jx[l], d});
    d = rval[l ^ 1'b1];
    u_plc.issue({3'b110, l, INFO_CLR_JUDGE}, 3);
    chk({jdg[l], dout[l], dout[l ^ 1'b1]}, {9'h000, d});
    u_plc.issue(8'hC3 | (8'($random(seed)) & 8'h1C), 3);
    chk(error_out, 1'b1);
    apb(1'b1, OFF_MASK, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({q[ST_ERR], irq}, 2'h3);
    u_plc.issue({3'b110, 1'b1, INFO_CLR_ERR}, 3);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({error_out, q[ST_ERR], irq}, 3'h0);
    u_plc.issue(8'hCF, 3);
    apb(1'b1, OFF_STATUS, 32'hF);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({error_out, q[ST_W-1:0], irq}, 6'h20);
    b = nst[1];
    b0 = nst[0];
    u_plc.issue(8'h9F, 40);
    repeat (10) @(posedge pclk);
    chk({nst[1] - b > 2, nst[0] == b0}, 2'h3);
    // Reset in mid-run restores defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk({q[1:0], error_out, rdy[0], rdy[1]}, 5'h1B);
    summarize();
  end
endmodule
